/* rtl/vcs_pkg.sv */
package vcs_pkg;
  // clock and control timing
  localparam int CLK_HZ = 25000000;
  localparam int CARRIER_HZ = 10000;
  localparam int CTRL_PERIOD_US = 200;
  localparam int CTRL_CYCLES = CTRL_PERIOD_US * (CLK_HZ / 1000000);
  localparam int CARRIER_CYCLES = CLK_HZ / CARRIER_HZ;
  localparam int ALIGN_MS = 500;
  localparam int ALIGN_TICKS = (ALIGN_MS * 1000) / CTRL_PERIOD_US;
  // converter scaling
  localparam int ADC_FULL = 1023;
  localparam logic signed [10:0] I_ZERO_CODE = 11'sh200;
  localparam int I_FS_A = 10;
  localparam int OC_LIMIT_A = 4;
  localparam logic [11:0] OC_LIMIT_CODE = 12'((OC_LIMIT_A * 1024 + 2 * I_FS_A - 1) / (2 * I_FS_A));
  localparam int VDC_FS_V = 30;
  localparam int OV_LIMIT_V = 28;
  localparam logic [9:0] OV_LIMIT_CODE = 10'((OV_LIMIT_V * ADC_FULL) / VDC_FS_V);
  localparam int UV_LIMIT_V = 0;
  localparam logic signed [10:0] UV_LIMIT_CODE = 11'((UV_LIMIT_V * ADC_FULL) / VDC_FS_V);
  // speed scaling
  localparam int SPD_MIN_RPM = 600;
  localparam int SPD_MAX_RPM = 2000;
  localparam int OS_LIMIT_RPM = 2200;
  localparam int ENC_EDGES_PER_REV = 400;
  localparam logic [31:0] RPM_NUM = 32'((60 * CLK_HZ) / ENC_EDGES_PER_REV);
  // regulator gains, Q8
  localparam int GAIN_SHIFT = 8;
  localparam int KP_SPD = 64;
  localparam int KI_SPD = 2;
  localparam int KP_ID = 128;
  localparam int KI_ID = 16;
  localparam int KP_IQ = 128;
  localparam int KI_IQ = 16;
  localparam int INT_LIMIT = 262144;
  localparam int IQ_LIMIT = 180;
  localparam int V_LIMIT = 1023;
  localparam logic signed [31:0] ALIGN_ID_CODE = 32'sh00000033;
  // decoupling constants, Q16
  localparam int DEC_SHIFT = 16;
  localparam int LD_K = 40;
  localparam int LQ_K = 40;
  localparam int PSI_K = 2000;
  // trigonometry, Q10
  localparam int TRIG_SHIFT = 10;
  localparam int INV_SQRT3 = 591;
  localparam int SQRT3 = 1774;
  // trip flag positions
  localparam int FLT_OC = 0;
  localparam int FLT_OV = 1;
  localparam int FLT_UV = 2;
  localparam int FLT_OS = 3;
  // drive modes
  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_ALIGN = 2'b01,
    MODE_RUN = 2'b10,
    MODE_TRIP = 2'b11
  } vcs_mode_type;
endpackage : vcs_pkg

/* rtl/vcs_core.sv */
`timescale 1ns/1ns
// Operation
// - Park transform of phase currents, d on magnet north, q ninety degrees ahead.
// - In speed regulation the d axis current command is zero.
// - Speed PI regulator on speed error yields the q current command.
// - Separate d/q current PI regulators with decoupling feed-forward terms.
// - Pulse width from triangular carrier compared to phase voltage command.
// - Modulation factor is command voltage over bus voltage, loaded into duty.
// - Run switch sampled; low requests rotation, high requests stop.
// - Speed code maps linearly 600 rpm at zero to 2000 rpm at full scale.
// - Bus voltage code maps linearly zero to thirty volts.
// - Phase current code maps linearly minus ten to plus ten amperes.
// - Low hardware fault input disables all six outputs without software.
// - Each control period, any phase current over four amperes trips.
// - Each control period, bus voltage over twenty-eight volts trips.
// - Each control period, bus voltage below zero volts trips.
// - Each control period, rotor speed over 2200 rpm trips.
// - Startup aligns rotor on d axis, then after fixed time runs vector control.
// - Rotor speed is computed from captured encoder timer counts.
// - Control period is twice the 10 kHz carrier period.
module vcs_core #(
  parameter int CTRL_CYCLES = vcs_pkg::CTRL_CYCLES,
  parameter int ALIGN_TICKS = vcs_pkg::ALIGN_TICKS
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  // pins from the user side and the power stage
  input wire logic run_switch_pin,
  input wire logic hw_fault_input_n,
  // converter results
  input wire logic adc_valid,
  input wire logic [9:0] speed_cmd_channel,
  input wire logic [9:0] bus_voltage_channel,
  input wire logic [9:0] u_current_channel,
  input wire logic [9:0] w_current_channel,
  // encoder capture
  input wire logic enc_edge,
  input wire logic [15:0] enc_period,
  input wire logic [9:0] rotor_angle,
  // inverter drive
  output logic [5:0] pwm_drive,
  output logic [5:0] pwm_oe,
  // status
  output logic [3:0] trip_flags,
  output logic [1:0] drive_mode,
  output logic [11:0] speed_rpm
);
  localparam logic [15:0] PEAK = 16'(CTRL_CYCLES / 4);

  // quarter-wave sine, Q10, index 0 at zero and 16 at the crest
  localparam logic [16:0][11:0] QTR = {12'h400, 12'h3FB, 12'h3EC, 12'h3D4, 12'h3B2, 12'h387, 12'h353, 12'h318,
    12'h2D4, 12'h28A, 12'h239, 12'h1E3, 12'h188, 12'h129, 12'h0C8, 12'h064, 12'h000};
  function automatic logic signed [11:0] vcs_qtr(input logic [4:0] i);
    vcs_qtr = (i > 5'h10) ? 12'sh400 : $signed(QTR[i]);
  endfunction : vcs_qtr

  // sine of a 64-step electrical phase, Q10
  function automatic logic signed [31:0] vcs_sin(input logic [5:0] p);
    logic signed [11:0] m;
    m = p[4] ? vcs_qtr(5'h10 - {1'b0, p[3:0]}) : vcs_qtr({1'b0, p[3:0]});
    vcs_sin = p[5] ? -32'(m) : 32'(m);
  endfunction : vcs_sin

  function automatic logic signed [31:0] vcs_sat(input logic signed [31:0] v, input int lim);
    vcs_sat = (v > lim) ? 32'(lim) : ((v < -lim) ? -32'(lim) : v);
  endfunction : vcs_sat

  function automatic logic [11:0] vcs_abs(input logic signed [11:0] v);
    vcs_abs = v[11] ? 12'(-v) : 12'(v);
  endfunction : vcs_abs

  // duty compare value from phase voltage and bus voltage
  function automatic logic [15:0] vcs_duty(input logic signed [31:0] v, input logic [9:0] vdc);
    logic signed [31:0] m;
    logic signed [31:0] c;
    m = (vdc == 10'h000) ? 32'sh0 : (v <<< vcs_pkg::TRIG_SHIFT) / $signed({22'h0, vdc});
    c = $signed({16'h0, PEAK}) / 2 + ((m * $signed({16'h0, PEAK})) >>> 11);
    vcs_duty = (c < 0) ? 16'h0000 : ((c > $signed({16'h0, PEAK})) ? PEAK : c[15:0]);
  endfunction : vcs_duty

  vcs_pkg::vcs_mode_type mode, next_mode;
  logic [2:0] run_sync, flt_sync, step;
  logic run_lvl, flt_lvl, run_req, hw_fault, car_down, car_half, ctrl_tick, drive_en, active;
  logic [15:0] carrier, align_cnt, cmp_u, cmp_v, cmp_w;
  logic signed [11:0] iu, iw, iv;
  logic [9:0] vdc, angle_offset, ang;
  logic [11:0] spd_ref;
  logic [3:0] fault_evt;
  logic [31:0] rpm_q;
  logic signed [31:0] s_sin, s_cos, alpha, beta, id, iq, id_ref, iq_ref, sp_int, d_int, q_int;
  logic signed [31:0] vd, vq, spd_err, ed, eq, w_mech, valpha, vbeta, vb3;

  // pin synchronisers, a level counts once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (srst) begin
      run_sync <= 3'h7;
      flt_sync <= 3'h7;
      run_lvl <= 1'b1;
      flt_lvl <= 1'b1;
    end else if (clk_en) begin
      run_sync <= {run_sync[1:0], run_switch_pin};
      flt_sync <= {flt_sync[1:0], hw_fault_input_n};
      if (run_sync[1] == run_sync[2]) run_lvl <= run_sync[2];
      if (flt_sync[1] == flt_sync[2]) flt_lvl <= flt_sync[2];
    end
  end

  assign run_req = ~run_lvl;
  assign hw_fault = ~flt_lvl;
  assign active = (mode == vcs_pkg::MODE_ALIGN) || (mode == vcs_pkg::MODE_RUN);

  // triangular carrier; control tick on every second valley
  always_ff @(posedge core_clk) begin
    if (srst) begin
      carrier <= 16'h0000;
      car_down <= 1'b0;
      car_half <= 1'b0;
      ctrl_tick <= 1'b0;
    end else if (clk_en) begin
      ctrl_tick <= 1'b0;
      if (!car_down) begin
        carrier <= carrier + 16'h0001;
        if (carrier == PEAK - 16'h0001) car_down <= 1'b1;
      end else begin
        carrier <= carrier - 16'h0001;
        if (carrier == 16'h0001) begin
          car_down <= 1'b0;
          car_half <= ~car_half;
          ctrl_tick <= car_half;
        end
      end
    end
  end

  // converter capture and scaling
  always_ff @(posedge core_clk) begin
    if (srst) begin
      iu <= 12'sh000;
      iw <= 12'sh000;
      vdc <= 10'h000;
      spd_ref <= 12'(vcs_pkg::SPD_MIN_RPM);
    end else if (clk_en && adc_valid) begin
      iu <= 12'($signed({1'b0, u_current_channel}) - vcs_pkg::I_ZERO_CODE);
      iw <= 12'($signed({1'b0, w_current_channel}) - vcs_pkg::I_ZERO_CODE);
      vdc <= bus_voltage_channel;
      spd_ref <= 12'(vcs_pkg::SPD_MIN_RPM + (int'(speed_cmd_channel)
        * (vcs_pkg::SPD_MAX_RPM - vcs_pkg::SPD_MIN_RPM)) / vcs_pkg::ADC_FULL);
    end
  end

  assign iv = -(iu + iw);

  // rotor speed from encoder period count
  assign rpm_q = vcs_pkg::RPM_NUM / {16'h0000, enc_period};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      speed_rpm <= 12'h000;
    end else if (clk_en && enc_edge) begin
      speed_rpm <= (enc_period == 16'h0000 || rpm_q > 32'h00000FFF) ? 12'hFFF : rpm_q[11:0];
    end
  end

  // fault checks evaluated on each control tick
  always_comb begin
    fault_evt = 4'h0;
    if (ctrl_tick) begin
      fault_evt[vcs_pkg::FLT_OC] = (vcs_abs(iu) >= vcs_pkg::OC_LIMIT_CODE)
        || (vcs_abs(iv) >= vcs_pkg::OC_LIMIT_CODE)
        || (vcs_abs(iw) >= vcs_pkg::OC_LIMIT_CODE);
      fault_evt[vcs_pkg::FLT_OV] = vdc > vcs_pkg::OV_LIMIT_CODE;
      fault_evt[vcs_pkg::FLT_UV] = $signed({1'b0, vdc}) < vcs_pkg::UV_LIMIT_CODE;
      fault_evt[vcs_pkg::FLT_OS] = speed_rpm > 12'(vcs_pkg::OS_LIMIT_RPM);
    end
  end

  // drive mode sequencing; a trip waits for the run request to drop
  always_comb begin
    next_mode = mode;
    case (mode)
      vcs_pkg::MODE_IDLE: begin
        if (run_req && fault_evt == 4'h0 && !hw_fault) next_mode = vcs_pkg::MODE_ALIGN;
      end
      vcs_pkg::MODE_ALIGN: begin
        if (fault_evt != 4'h0 || hw_fault) next_mode = vcs_pkg::MODE_TRIP;
        else if (!run_req) next_mode = vcs_pkg::MODE_IDLE;
        else if (ctrl_tick && align_cnt == 16'(ALIGN_TICKS - 1)) next_mode = vcs_pkg::MODE_RUN;
      end
      vcs_pkg::MODE_RUN: begin
        if (fault_evt != 4'h0 || hw_fault) next_mode = vcs_pkg::MODE_TRIP;
        else if (!run_req) next_mode = vcs_pkg::MODE_IDLE;
      end
      vcs_pkg::MODE_TRIP: begin
        if (!run_req) next_mode = vcs_pkg::MODE_IDLE;
      end
      default: next_mode = vcs_pkg::MODE_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode <= vcs_pkg::MODE_IDLE;
      trip_flags <= 4'h0;
      align_cnt <= 16'h0000;
      angle_offset <= 10'h000;
    end else if (clk_en) begin
      mode <= next_mode;
      // new fault events always land; flags clear only on a fresh start
      if (mode == vcs_pkg::MODE_IDLE && next_mode == vcs_pkg::MODE_ALIGN) trip_flags <= fault_evt;
      else trip_flags <= trip_flags | fault_evt;
      if (mode != vcs_pkg::MODE_ALIGN) align_cnt <= 16'h0000;
      else if (ctrl_tick) align_cnt <= align_cnt + 16'h0001;
      if (mode == vcs_pkg::MODE_ALIGN && next_mode == vcs_pkg::MODE_RUN) angle_offset <= rotor_angle;
    end
  end

  assign drive_mode = mode;

  // calculation steps after each tick
  always_ff @(posedge core_clk) begin
    if (srst) step <= 3'h0;
    else if (clk_en) begin
      if (ctrl_tick) step <= 3'h1;
      else if (step == 3'h4) step <= 3'h0;
      else if (step != 3'h0) step <= step + 3'h1;
    end
  end

  // rotating frame angle, held at zero while aligning
  assign ang = (mode == vcs_pkg::MODE_RUN) ? rotor_angle - angle_offset : 10'h000;
  assign s_sin = vcs_sin(ang[9:4]);
  assign s_cos = vcs_sin(ang[9:4] + 6'h10);
  assign alpha = 32'(iu);
  assign beta = (-(32'(iu) + 2 * 32'(iw)) * vcs_pkg::INV_SQRT3) >>> vcs_pkg::TRIG_SHIFT;
  assign spd_err = 32'(spd_ref) - 32'(speed_rpm);
  assign ed = id_ref - id;
  assign eq = iq_ref - iq;
  assign w_mech = 32'(speed_rpm);

  // d/q projection of measured currents
  always_ff @(posedge core_clk) begin
    if (srst) begin
      id <= 32'sh0;
      iq <= 32'sh0;
    end else if (clk_en && step == 3'h1) begin
      id <= (alpha * s_cos + beta * s_sin) >>> vcs_pkg::TRIG_SHIFT;
      iq <= (beta * s_cos - alpha * s_sin) >>> vcs_pkg::TRIG_SHIFT;
    end
  end

  // speed and current regulators
  always_ff @(posedge core_clk) begin
    if (srst || (clk_en && !active)) begin
      id_ref <= 32'sh0;
      iq_ref <= 32'sh0;
      sp_int <= 32'sh0;
      d_int <= 32'sh0;
      q_int <= 32'sh0;
      vd <= 32'sh0;
      vq <= 32'sh0;
    end else if (clk_en) begin
      if (step == 3'h2 && mode == vcs_pkg::MODE_ALIGN) begin
        id_ref <= vcs_pkg::ALIGN_ID_CODE;
        iq_ref <= 32'sh0;
      end else if (step == 3'h2) begin
        id_ref <= 32'sh0;
        sp_int <= vcs_sat(sp_int + vcs_pkg::KI_SPD * spd_err, vcs_pkg::INT_LIMIT);
        iq_ref <= vcs_sat((vcs_pkg::KP_SPD * spd_err + sp_int) >>> vcs_pkg::GAIN_SHIFT, vcs_pkg::IQ_LIMIT);
      end
      if (step == 3'h3) begin
        d_int <= vcs_sat(d_int + vcs_pkg::KI_ID * ed, vcs_pkg::INT_LIMIT);
        q_int <= vcs_sat(q_int + vcs_pkg::KI_IQ * eq, vcs_pkg::INT_LIMIT);
        vd <= vcs_sat(((vcs_pkg::KP_ID * ed + d_int) >>> vcs_pkg::GAIN_SHIFT)
          - ((w_mech * vcs_pkg::LQ_K * iq) >>> vcs_pkg::DEC_SHIFT), vcs_pkg::V_LIMIT);
        vq <= vcs_sat(((vcs_pkg::KP_IQ * eq + q_int) >>> vcs_pkg::GAIN_SHIFT)
          + ((w_mech * (vcs_pkg::LD_K * id + vcs_pkg::PSI_K)) >>> vcs_pkg::DEC_SHIFT), vcs_pkg::V_LIMIT);
      end
    end
  end

  // back to phase voltages, then duty via modulation factor
  assign valpha = (vd * s_cos - vq * s_sin) >>> vcs_pkg::TRIG_SHIFT;
  assign vbeta = (vd * s_sin + vq * s_cos) >>> vcs_pkg::TRIG_SHIFT;
  assign vb3 = (vbeta * vcs_pkg::SQRT3) >>> vcs_pkg::TRIG_SHIFT;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmp_u <= PEAK >> 1;
      cmp_v <= PEAK >> 1;
      cmp_w <= PEAK >> 1;
    end else if (clk_en && step == 3'h4) begin
      cmp_u <= vcs_duty(valpha, vdc);
      cmp_v <= vcs_duty((vb3 - valpha) >>> 1, vdc);
      cmp_w <= vcs_duty((-valpha - vb3) >>> 1, vdc);
    end
  end

  // gate outputs, hardware fault cuts drive at once
  assign drive_en = active && !hw_fault;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pwm_drive <= 6'h00;
      pwm_oe <= 6'h00;
    end else if (clk_en) begin
      pwm_oe <= {6{drive_en}};
      pwm_drive <= drive_en ? {carrier < cmp_u, carrier >= cmp_u, carrier < cmp_v,
        carrier >= cmp_v, carrier < cmp_w, carrier >= cmp_w} : 6'h00;
    end
  end

  // helper: enabled cycles since last tick
  logic [15:0] tick_gap;
  logic tick_seen;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tick_gap <= 16'h0000;
      tick_seen <= 1'b0;
    end else if (clk_en) begin
      tick_gap <= ctrl_tick ? 16'h0000 : tick_gap + 16'h0001;
      if (ctrl_tick) tick_seen <= 1'b1;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  a_tick_period: assert property (clk_en && ctrl_tick && tick_seen |-> tick_gap == 16'(CTRL_CYCLES - 1))
    else $error("control tick spacing wrong");
  a_hw_fault_off: assert property (clk_en && hw_fault |=> pwm_oe == 6'h00 && pwm_drive == 6'h00)
    else $error("outputs driven during hardware fault");
  a_trip_holds: assert property (mode == vcs_pkg::MODE_TRIP && run_req |=> mode == vcs_pkg::MODE_TRIP)
    else $error("trip left while run still requested");
  a_trip_outputs: assert property (mode == vcs_pkg::MODE_TRIP ##1 mode == vcs_pkg::MODE_TRIP |-> pwm_oe == 6'h00)
    else $error("outputs enabled while tripped");
  a_oc_trip: assert property (clk_en && active && fault_evt[vcs_pkg::FLT_OC]
    |=> mode == vcs_pkg::MODE_TRIP && trip_flags[vcs_pkg::FLT_OC])
    else $error("overcurrent did not trip");
  a_ov_trip: assert property (clk_en && active && ctrl_tick && vdc > vcs_pkg::OV_LIMIT_CODE
    |=> mode == vcs_pkg::MODE_TRIP)
    else $error("overvoltage did not trip");
  a_uv_trip: assert property (clk_en && active && fault_evt[vcs_pkg::FLT_UV] |=> mode == vcs_pkg::MODE_TRIP)
    else $error("undervoltage did not trip");
  a_os_trip: assert property (clk_en && active && ctrl_tick && speed_rpm > 12'(vcs_pkg::OS_LIMIT_RPM)
    |=> trip_flags[vcs_pkg::FLT_OS])
    else $error("overspeed did not trip");
  a_id_zero: assert property (mode == vcs_pkg::MODE_RUN && $past(mode) == vcs_pkg::MODE_RUN
    && $past(clk_en) && $past(step) == 3'h2 |-> id_ref == 32'sh0)
    else $error("d current command not zero");
  a_stop_req: assert property (clk_en && mode == vcs_pkg::MODE_RUN && !run_req && fault_evt == 4'h0
    && !hw_fault |=> mode == vcs_pkg::MODE_IDLE)
    else $error("stop request ignored");
  a_pwm_compare: assert property (clk_en && drive_en |=> pwm_drive[5] == ($past(carrier) < $past(cmp_u))
    && pwm_drive[4] != pwm_drive[5])
    else $error("pwm compare mismatch");
  a_speed_range: assert property (spd_ref >= 12'(vcs_pkg::SPD_MIN_RPM) && spd_ref <= 12'(vcs_pkg::SPD_MAX_RPM))
    else $error("speed command out of range");

  c_align_run: cover property (mode == vcs_pkg::MODE_ALIGN ##1 mode == vcs_pkg::MODE_RUN);
  c_trip: cover property (active ##1 mode == vcs_pkg::MODE_TRIP);
  c_restart: cover property (mode == vcs_pkg::MODE_TRIP ##1 mode == vcs_pkg::MODE_IDLE);
  c_hw_fault: cover property (drive_en ##1 hw_fault);
endmodule : vcs_core

/* dv/vcs_inverter_model.sv */
`timescale 1ns/1ns
// inverter stage, current and bus sensing, encoder and overcurrent comparator
module vcs_inverter_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // drive from the core
  input wire logic [5:0] pwm_drive,
  input wire logic [5:0] pwm_oe,
  // operating point set by the bench
  input wire logic [9:0] bias_i,
  input wire logic [9:0] vdc_code,
  input wire logic [15:0] enc_n,
  input wire logic fault_req,
  // sensed values back to the core
  output logic adc_valid,
  output logic [9:0] u_current_channel,
  output logic [9:0] w_current_channel,
  output logic [9:0] bus_voltage_channel,
  output logic enc_edge,
  output logic [15:0] enc_period,
  output logic [9:0] rotor_angle,
  output logic hw_fault_input_n
);
  logic [5:0] div;
  logic ripple;
  // conversions every 32 cycles, encoder edge every 64
  always_ff @(posedge core_clk) begin
    if (srst) begin
      div <= 6'h00;
      adc_valid <= 1'b0;
      enc_edge <= 1'b0;
      rotor_angle <= 10'h000;
    end else begin
      div <= div + 6'h01;
      adc_valid <= (div[4:0] == 5'h1F);
      enc_edge <= (div == 6'h3F);
      if (div == 6'h3F) rotor_angle <= rotor_angle + 10'h010;
    end
  end
  // one code of ripple from the upper u switch, opposite on w
  assign ripple = pwm_oe[5] & pwm_drive[5];
  assign u_current_channel = 10'h200 + bias_i + {9'h000, ripple};
  assign w_current_channel = 10'h200 - {9'h000, ripple};
  assign bus_voltage_channel = vdc_code;
  assign enc_period = enc_n;
  assign hw_fault_input_n = ~fault_req;
endmodule : vcs_inverter_model

/* dv/vcs_core_bench.sv */
`timescale 1ns/1ns
module vcs_core_bench;
  localparam int CTRL = 400;
  localparam int ALIGN = 3;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic run_switch_pin = 1'b1;
  logic [9:0] speed_cmd_channel = 10'h000;
  logic [9:0] bias_i = 10'h000;
  logic [9:0] vdc_code = 10'h280;
  logic [15:0] enc_n = 16'h07D0;
  logic fault_req = 1'b0;
  logic adc_valid, enc_edge, hw_fault_input_n;
  logic [9:0] u_current_channel, w_current_channel, bus_voltage_channel, rotor_angle;
  logic [15:0] enc_period;
  logic [5:0] pwm_drive, pwm_oe;
  logic [3:0] trip_flags;
  logic [1:0] drive_mode;
  logic [11:0] speed_rpm;
  logic [13:0] snap;
  int num_errors = 0;
  int checks = 0;
  int n;
  int kind [6] = '{0, 0, 1, 1, 2, 2};
  int val [6] = '{954, 955, 203, 206, 1704, 1700};
  logic [3:0] flg [6] = '{4'h0, 4'h2, 4'h0, 4'h1, 4'h0, 4'h8};
  int encs [4] = '{0, 1, 916, 915};

  vcs_core #(.CTRL_CYCLES(CTRL), .ALIGN_TICKS(ALIGN)) vcs_core_inst (
    .core_clk(core_clk), .srst(srst), .clk_en(clk_en), .run_switch_pin(run_switch_pin),
    .hw_fault_input_n(hw_fault_input_n), .adc_valid(adc_valid), .speed_cmd_channel(speed_cmd_channel),
    .bus_voltage_channel(bus_voltage_channel), .u_current_channel(u_current_channel),
    .w_current_channel(w_current_channel), .enc_edge(enc_edge), .enc_period(enc_period),
    .rotor_angle(rotor_angle), .pwm_drive(pwm_drive), .pwm_oe(pwm_oe), .trip_flags(trip_flags),
    .drive_mode(drive_mode), .speed_rpm(speed_rpm));
  vcs_inverter_model vcs_inverter_model_inst (
    .core_clk(core_clk), .srst(srst), .pwm_drive(pwm_drive), .pwm_oe(pwm_oe), .bias_i(bias_i),
    .vdc_code(vdc_code), .enc_n(enc_n), .fault_req(fault_req), .adc_valid(adc_valid),
    .u_current_channel(u_current_channel), .w_current_channel(w_current_channel),
    .bus_voltage_channel(bus_voltage_channel), .enc_edge(enc_edge), .enc_period(enc_period),
    .rotor_angle(rotor_angle), .hw_fault_input_n(hw_fault_input_n));

  // 25 MHz clock
  always #20 core_clk = ~core_clk;

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic wait_mode(input logic [1:0] m, input int lim, output int k);
    k = 0;
    while (drive_mode !== m && k < lim) begin
      cyc(1);
      k++;
    end
  endtask : wait_mode

  // expected speed reading for a captured encoder period
  function automatic logic [11:0] exp_rpm(input int p);
    if (p == 0) return 12'hFFF;
    if (int'(vcs_pkg::RPM_NUM) / p > 4095) return 12'hFFF;
    return 12'(int'(vcs_pkg::RPM_NUM) / p);
  endfunction : exp_rpm

  task automatic start;
    run_switch_pin = 1'b0;
    wait_mode(2'b01, 20, n);
    check("drive_mode start", drive_mode, 2'b01);
    cyc(2);
    check("pwm_oe start", pwm_oe, 6'h3F);
  endtask : start

  task automatic stop;
    run_switch_pin = 1'b1;
    wait_mode(2'b00, 20, n);
    cyc(1);
    check("drive_mode stop", drive_mode, 2'b00);
    check("pwm_oe stop", pwm_oe, 6'h00);
  endtask : stop

  task automatic stop_test;
    if (num_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // cut a hang short
  initial begin
    #(40 * 60000);
    num_errors++;
    stop_test();
  end

  // main sequence
  initial begin
    void'($urandom(32'had49983b));
    cyc(8);
    srst = 1'b0;
    cyc(1);
    check("reset outputs", {pwm_oe, pwm_drive, trip_flags, drive_mode, speed_rpm}, 30'h0);
    // speed from captured periods, corners then random
    for (int k = 0; k < 10; k++) begin
      enc_n = (k < 4) ? 16'(encs[k]) : 16'(900 + $urandom % 59000);
      n = 0;
      while (enc_edge !== 1'b1 && n < 70) begin
        cyc(1);
        n++;
      end
      cyc(1);
      check("speed_rpm", speed_rpm, exp_rpm(int'(enc_n)));
    end
    enc_n = 16'h07D0;
    // align then vector control
    start();
    wait_mode(2'b10, ALIGN * CTRL + CTRL + 20, n);
    check("drive_mode run", drive_mode, 2'b10);
    check("align not short", n >= (ALIGN - 1) * CTRL - 20, 1);
    for (int k = 0; k < 1500; k++) begin
      if (k % 100 == 0) speed_cmd_channel = 10'($urandom);
      cyc(1);
      check("pwm pairs", {pwm_drive[5] ^ pwm_drive[4], pwm_drive[3] ^ pwm_drive[2],
        pwm_drive[1] ^ pwm_drive[0]}, 3'b111);
    end
    // clock enable low freezes the outputs
    snap = {pwm_drive, pwm_oe, drive_mode};
    clk_en = 1'b0;
    cyc(30);
    check("frozen outputs", {pwm_drive, pwm_oe, drive_mode}, snap);
    clk_en = 1'b1;
    stop();
    check("pwm_drive stop", pwm_drive, 6'h00);
    // supervisor thresholds on both sides of the overvoltage, overcurrent and overspeed limits
    for (int k = 0; k < 6; k++) begin
      speed_cmd_channel = 10'($urandom);
      start();
      if (kind[k] == 0) vdc_code = 10'(val[k]);
      if (kind[k] == 1) bias_i = 10'(val[k]);
      if (kind[k] == 2) enc_n = 16'(val[k]);
      cyc(2 * CTRL + 80);
      check("trip_flags", trip_flags, flg[k]);
      check("tripped", drive_mode == 2'b11, flg[k] != 4'h0);
      if (flg[k] != 4'h0) begin
        check("pwm_oe trip", pwm_oe, 6'h00);
        vdc_code = 10'h280;
        bias_i = 10'h000;
        enc_n = 16'h07D0;
        cyc(CTRL + 10);
        check("trip held", drive_mode, 2'b11);
      end
      vdc_code = 10'h280;
      bias_i = 10'h000;
      enc_n = 16'h07D0;
      stop();
    end
    // hardware overcurrent input
    start();
    fault_req = 1'b1;
    cyc(8);
    check("pwm_oe hw fault", pwm_oe, 6'h00);
    check("pwm_drive hw fault", pwm_drive, 6'h00);
    fault_req = 1'b0;
    cyc(20);
    check("hw fault held", drive_mode, 2'b11);
    stop();
    start();
    check("restart flags", trip_flags, 4'h0);
    // reset in mid-run while run is still requested
    srst = 1'b1;
    cyc(2);
    srst = 1'b0;
    cyc(1);
    check("mid-run reset outputs", {pwm_oe, pwm_drive, trip_flags, drive_mode, speed_rpm}, 30'h0);
    stop();
    stop_test();
  end
endmodule : vcs_core_bench
